/* verilog/ocd_pkg.sv */
`default_nettype none
package ocd_pkg;
    // Frame and channel geometry
    localparam int FRAME_BITS  = 16;
    localparam int N_CH        = 8;
    localparam int CODE_W      = 10;
    localparam int DATA_W      = 16;
    localparam int ADDR_W      = 5;
    // Edge count positions inside a frame
    localparam logic [4:0] EDGE_ABORT = 5'h0F;
    localparam logic [4:0] EDGE_FULL  = 5'h10;
    localparam logic [4:0] EDGE_FLAG  = 5'h0E;
    // Chain shifter preload: a one that emerges on edge 15
    localparam logic [14:0] CHAIN_PRELOAD = 15'h0001;
    // Command nibble encodings
    localparam logic [3:0] CMD_REG_ONLY = 4'h8;
    localparam logic [3:0] CMD_WR_THRU  = 4'h9;
    localparam logic [3:0] CMD_UPD_SEL  = 4'hA;
    localparam logic [3:0] CMD_CHA_WR   = 4'hB;
    localparam logic [3:0] CMD_BCAST    = 4'hC;
    localparam logic [3:0] CMD_PD_HIZ   = 4'hD;
    localparam logic [3:0] CMD_PD_100K  = 4'hE;
    localparam logic [3:0] CMD_PD_2K5   = 4'hF;
    // Field positions in the frame word
    localparam int CMD_MSB  = 15;
    localparam int CMD_LSB  = 12;
    localparam int CH_MSB   = 14;
    localparam int CH_LSB   = 12;
    localparam int CODE_MSB = 11;
    localparam int CODE_LSB = 2;
    // Register map (word index on the plain port)
    localparam logic [4:0] OFS_HOLD   = 5'h00;
    localparam logic [4:0] OFS_OUT    = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    localparam logic [4:0] OFS_CTRL   = 5'h11;
    // Reset values
    localparam logic       CTRL_RESET = 1'h1;
    localparam logic [9:0] CODE_RESET = 10'h000;
    // Operating mode and power-down terminations
    typedef enum logic {MODE_REG_ONLY = 1'b0, MODE_WR_THRU = 1'b1} ocd_mode_e;
    typedef enum logic [1:0] {
        PD_ACTIVE = 2'b00,
        PD_HIZ    = 2'b01,
        PD_100K   = 2'b10,
        PD_2K5    = 2'b11
    } ocd_pd_e;
endpackage
`default_nettype wire

/* verilog/ocd_core_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ocd_core_if;
    import ocd_pkg::*;
    // Link events seen in the system clock domain
    logic              sclk_fall;
    logic              sync_fall;
    logic              sync_rise;
    logic              sync_low;
    logic              din_bit;
    logic              dout_en;
    // Captured frame and chained output
    logic [15:0]       frame_word;
    logic              frame_exec;
    logic              dout_bit;
    // Channel bank control and state
    logic [7:0]        hold_we;
    logic [9:0]        hold_wdata;
    logic [7:0]        out_load;
    logic [7:0]        pd_we;
    ocd_pd_e           pd_mode;
    logic [3:0]        rd_idx;
    logic [9:0]        rd_data;
    logic [9:0]        out_code [8];
    ocd_pd_e           pd_state [8];
    modport shf  (input sclk_fall, sync_fall, sync_rise, sync_low, din_bit,
                  dout_en, output frame_word, frame_exec, dout_bit);
    modport bank (input hold_we, hold_wdata, out_load, pd_we, pd_mode,
                  rd_idx, output rd_data, out_code, pd_state);
    modport core (output sclk_fall, sync_fall, sync_rise, sync_low, din_bit,
                  dout_en, hold_we, hold_wdata, out_load, pd_we, pd_mode,
                  rd_idx, input frame_word, frame_exec, dout_bit, rd_data,
                  out_code, pd_state);
endinterface
`default_nettype wire

/* verilog/ocd_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
module ocd_shifter (
    // System clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Link side events and frame output
    ocd_core_if.shf   lk
);
    import ocd_pkg::*;

    logic [15:0] sr_reg;     // Input shift register
    logic [4:0]  cnt_reg;    // Falling edges, saturating at 16
    logic [14:0] chain_reg;  // Delay line toward the chain output
    logic        dout_reg;   // Registered chain output
    logic        exec_reg;   // One-cycle execute pulse

    // Shift on every falling edge, MSB first; a new frame clears the edge count, not the shift register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sr_reg  <= 16'h0000;
            cnt_reg <= 5'h00;
        end else if (lk.sync_fall) begin
            cnt_reg <= 5'h00;
        end else if (lk.sync_low && lk.sclk_fall) begin
            sr_reg <= {sr_reg[14:0], lk.din_bit};
            if (cnt_reg != EDGE_FULL) begin
                cnt_reg <= cnt_reg + 5'h01;
            end
        end
    end

    // Chain output: low for 14 edges, high on 15, then the first bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chain_reg <= CHAIN_PRELOAD;
            dout_reg  <= 1'b0;
        end else if (!lk.sync_low) begin
            // Idle frame sync keeps the chain quiet
            chain_reg <= CHAIN_PRELOAD;
            dout_reg  <= 1'b0;
        end else if (lk.sclk_fall) begin
            dout_reg  <= chain_reg[14] & lk.dout_en;
            chain_reg <= {chain_reg[13:0], lk.din_bit};
        end
    end

    // Execute on the rising frame sync only once 16 edges were seen;
    // the register then holds this device's final 16 bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            exec_reg <= 1'b0;
        end else begin
            exec_reg <= lk.sync_rise
                        && (cnt_reg == EDGE_FULL);
        end
    end

    assign lk.frame_word = sr_reg;
    assign lk.frame_exec = exec_reg;
    assign lk.dout_bit   = dout_reg;

    property p_abort;
        @(posedge clk_sys) disable iff (rst)
        lk.sync_rise && (cnt_reg < EDGE_ABORT) |=> !exec_reg;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Short frame was executed");

    property p_exec_rise;
        @(posedge clk_sys) disable iff (rst)
        exec_reg |-> $past(lk.sync_rise) && $past(cnt_reg) == EDGE_FULL;
    endproperty
    a_exec_rise: assert property (p_exec_rise)
        else $error("Execute without rising sync after 16 edges");

    property p_dout_flag;
        @(posedge clk_sys) disable iff (rst)
        lk.sync_low && lk.sclk_fall && !lk.sync_fall && lk.dout_en
        && cnt_reg == EDGE_FLAG |=> dout_reg;
    endproperty
    a_dout_flag: assert property (p_dout_flag)
        else $error("Chain output not high on edge 15");

    property p_dout_low;
        @(posedge clk_sys) disable iff (rst)
        lk.sync_low && lk.sclk_fall && !lk.sync_fall
        && cnt_reg < EDGE_FLAG |=> !dout_reg;
    endproperty
    a_dout_low: assert property (p_dout_low)
        else $error("Chain output high before edge 15");

    property p_shift;
        @(posedge clk_sys) disable iff (rst)
        lk.sync_low && lk.sclk_fall && !lk.sync_fall
        |=> sr_reg[0] == $past(lk.din_bit)
            && sr_reg[15:1] == $past(sr_reg[14:0]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("Shift register did not take the data bit");
endmodule
`default_nettype wire

/* verilog/ocd_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module ocd_bank (
    // System clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Channel control from the core
    ocd_core_if.bank  bk
);
    import ocd_pkg::*;

    logic [9:0] hold_reg [8];  // Holding registers
    logic [9:0] out_reg  [8];  // Output codes
    ocd_pd_e    pd_reg   [8];  // Power-down terminations
    logic [9:0] rd_reg;        // Registered read data

    // Per-channel update; an output load sees a same-cycle write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N_CH; i++) begin
                hold_reg[i] <= CODE_RESET;
                out_reg[i]  <= CODE_RESET;
                pd_reg[i]   <= PD_ACTIVE;
            end
        end else begin
            for (int i = 0; i < N_CH; i++) begin
                if (bk.hold_we[i]) begin
                    hold_reg[i] <= bk.hold_wdata;
                end
                if (bk.out_load[i]) begin
                    out_reg[i] <= bk.hold_we[i] ? bk.hold_wdata : hold_reg[i];
                    pd_reg[i]  <= PD_ACTIVE;
                end else if (bk.pd_we[i]) begin
                    pd_reg[i]  <= bk.pd_mode;
                end
            end
        end
    end

    // Read port: holding codes low half, output codes high half
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_reg <= CODE_RESET;
        end else if (bk.rd_idx[3]) begin
            rd_reg <= out_reg[bk.rd_idx[2:0]];
        end else begin
            rd_reg <= hold_reg[bk.rd_idx[2:0]];
        end
    end

    assign bk.rd_data  = rd_reg;
    assign bk.out_code = out_reg;
    assign bk.pd_state = pd_reg;
endmodule
`default_nettype wire

/* verilog/ocd_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ocd_top #(
    parameter int NUM_CH  = 8,   // Channels in the bank
    parameter int CODE_BW = 10   // Bits per channel code
) (
    // System clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    // Serial link pins
    input  wire logic                        sclk,
    input  wire logic                        sync_n,
    input  wire logic                        din,
    output logic                             dout,
    // Register port
    input  wire logic [ocd_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [ocd_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [ocd_pkg::DATA_W-1:0]  reg_rdata,
    // Converter side
    output logic      [79:0]                 dac_code,
    output logic      [15:0]                 dac_pd,
    output logic                             write_through
);
    import ocd_pkg::*;

    // Only the documented geometry is served
    if (NUM_CH != N_CH || CODE_BW != CODE_W) begin : g_chk
        $error("ocd_top serves eight 10-bit channels only");
    end

    // Decode a frame channel select into a one-hot channel
    function automatic logic [7:0] ch_onehot(input logic [2:0] ch);
        ch_onehot = 8'h01 << ch;
    endfunction

    ocd_core_if cif ();

    logic [2:0]  sclk_sy_reg;   // Clock pin synchroniser and history
    logic [2:0]  sync_sy_reg;   // Frame sync synchroniser and history
    logic [2:0]  din_sy_reg;    // Data synchroniser, aligned to clock
    ocd_mode_e   mode_reg;      // Current operating mode
    logic        ctrl_reg;      // Chain output enable
    logic        rd_bank_reg;   // Last read came from the bank
    logic        rd_hit_reg;    // Last read hit a core register
    logic [15:0] rd_core_reg;   // Core register read value
    logic [15:0] w;             // Frame word shorthand
    logic [3:0]  command_nibble;
    logic [2:0]  channel_select;
    logic [11:0] data_field;
    logic [9:0]  code_val;
    logic [7:0]  flags;
    logic [7:0]  pd_any;

    // Two flops before use; the third gives edge history and the data bit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // Idle-high history, so release never looks like a fall
            sclk_sy_reg <= 3'h7;
            sync_sy_reg <= 3'h7;
            din_sy_reg  <= 3'h0;
        end else begin
            sclk_sy_reg <= {sclk_sy_reg[1:0], sclk};
            sync_sy_reg <= {sync_sy_reg[1:0], sync_n};
            din_sy_reg  <= {din_sy_reg[1:0], din};
        end
    end

    // Link events; data taken from the cycle before the clock fell
    assign cif.sclk_fall = sclk_sy_reg[2] & ~sclk_sy_reg[1];
    assign cif.sync_fall = sync_sy_reg[2] & ~sync_sy_reg[1];
    assign cif.sync_rise = ~sync_sy_reg[2] & sync_sy_reg[1];
    assign cif.sync_low  = ~sync_sy_reg[1];
    assign cif.din_bit   = din_sy_reg[2];
    assign cif.dout_en   = ctrl_reg;

    ocd_shifter u_shf (
        .clk_sys (clk_sys),
        .rst     (rst),
        .lk      (cif.shf)
    );

    ocd_bank u_bank (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bk      (cif.bank)
    );

    // Frame fields
    assign w              = cif.frame_word;
    assign command_nibble = w[CMD_MSB:CMD_LSB];
    assign channel_select = w[CH_MSB:CH_LSB];
    assign data_field     = w[CODE_MSB:0];
    assign code_val       = data_field[CODE_MSB:CODE_LSB];
    assign flags          = w[7:0];

    // Operating mode; changes only on an executed mode command
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_reg <= MODE_REG_ONLY;
        end else if (cif.frame_exec) begin
            if (command_nibble == CMD_REG_ONLY) begin
                mode_reg <= MODE_REG_ONLY;
            end else if (command_nibble == CMD_WR_THRU) begin
                mode_reg <= MODE_WR_THRU;
            end
        end
    end

    // Command decode into bank strobes, valid in the execute cycle
    always_comb begin
        cif.hold_we    = 8'h00;
        cif.out_load   = 8'h00;
        cif.pd_we      = 8'h00;
        cif.pd_mode    = PD_ACTIVE;
        cif.hold_wdata = code_val;
        if (cif.frame_exec) begin
            if (!w[CMD_MSB]) begin
                // Channel write; output follows only in write-through
                cif.hold_we = ch_onehot(channel_select);
                if (mode_reg == MODE_WR_THRU) begin
                    cif.out_load = ch_onehot(channel_select);
                end else begin
                    cif.out_load = 8'h00;
                end
            end else begin
                // Special commands ignore the mode
                case (command_nibble)
                    CMD_UPD_SEL: begin
                        cif.out_load = flags;
                    end
                    CMD_CHA_WR: begin
                        cif.hold_we  = ch_onehot(3'h0);
                        cif.out_load = 8'hFF;
                    end
                    CMD_BCAST: begin
                        cif.hold_we  = 8'hFF;
                        cif.out_load = 8'hFF;
                    end
                    CMD_PD_HIZ: begin
                        cif.pd_we   = flags;
                        cif.pd_mode = PD_HIZ;
                    end
                    CMD_PD_100K: begin
                        cif.pd_we   = flags;
                        cif.pd_mode = PD_100K;
                    end
                    CMD_PD_2K5: begin
                        cif.pd_we   = flags;
                        cif.pd_mode = PD_2K5;
                    end
                    default: begin
                        // Mode commands carry no bank action
                        cif.pd_we = 8'h00;
                    end
                endcase
            end
        end
    end

    // Power-down summary per channel
    always_comb begin
        for (int i = 0; i < N_CH; i++) begin
            pd_any[i] = (cif.pd_state[i] != PD_ACTIVE);
        end
    end

    // Control register write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (reg_wr && reg_addr == OFS_CTRL) begin
            ctrl_reg <= reg_wdata[0];
        end
    end

    // Bank read index follows the address directly
    assign cif.rd_idx = reg_addr[3:0];

    // Read decode; answer appears the cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_bank_reg <= 1'b0;
            rd_hit_reg  <= 1'b0;
            rd_core_reg <= 16'h0000;
        end else begin
            rd_bank_reg <= 1'b0;
            rd_hit_reg  <= 1'b0;
            rd_core_reg <= 16'h0000;
            if (reg_rd) begin
                if (reg_addr < OFS_STATUS) begin
                    rd_bank_reg <= 1'b1;
                end else if (reg_addr == OFS_STATUS) begin
                    rd_hit_reg  <= 1'b1;
                    rd_core_reg <= {pd_any, 7'h00, mode_reg};
                end else if (reg_addr == OFS_CTRL) begin
                    rd_hit_reg  <= 1'b1;
                    rd_core_reg <= {15'h0000, ctrl_reg};
                end
            end
        end
    end

    // Unmapped and idle reads give zero
    always_comb begin
        if (rd_bank_reg) begin
            reg_rdata = {6'h00, cif.rd_data};
        end else if (rd_hit_reg) begin
            reg_rdata = rd_core_reg;
        end else begin
            reg_rdata = 16'h0000;
        end
    end

    // Converter side outputs, channel A in the low bits
    always_comb begin
        for (int i = 0; i < N_CH; i++) begin
            dac_code[i*10 +: 10] = cif.out_code[i];
            dac_pd[i*2 +: 2]     = cif.pd_state[i];
        end
    end

    assign dout          = cif.dout_bit;
    assign write_through = mode_reg;

    property p_mode_reg_only;
        @(posedge clk_sys) disable iff (rst)
        cif.frame_exec && command_nibble == CMD_REG_ONLY
        |=> mode_reg == MODE_REG_ONLY;
    endproperty
    a_mode_reg_only: assert property (p_mode_reg_only)
        else $error("Mode command 1000 not taken");

    property p_mode_wr_thru;
        @(posedge clk_sys) disable iff (rst)
        cif.frame_exec && command_nibble == CMD_WR_THRU
        |=> mode_reg == MODE_WR_THRU;
    endproperty
    a_mode_wr_thru: assert property (p_mode_wr_thru)
        else $error("Mode command 1001 not taken");

    property p_mode_keep;
        @(posedge clk_sys) disable iff (rst)
        !cif.frame_exec |=> $stable(mode_reg);
    endproperty
    a_mode_keep: assert property (p_mode_keep)
        else $error("Mode changed without a command");

    sequence s_chan_write;
        cif.frame_exec && !w[CMD_MSB];
    endsequence

    property p_reg_only_write;
        @(posedge clk_sys) disable iff (rst)
        s_chan_write ##0 mode_reg == MODE_REG_ONLY
        |=> dac_code == $past(dac_code);
    endproperty
    a_reg_only_write: assert property (p_reg_only_write)
        else $error("Register-only write moved an output");

    property p_wr_thru_write;
        @(posedge clk_sys) disable iff (rst)
        s_chan_write ##0 mode_reg == MODE_WR_THRU
        |=> cif.out_code[$past(channel_select)] == $past(code_val);
    endproperty
    a_wr_thru_write: assert property (p_wr_thru_write)
        else $error("Write-through output not updated");

    property p_bcast;
        @(posedge clk_sys) disable iff (rst)
        cif.frame_exec && command_nibble == CMD_BCAST
        |=> cif.out_code[7] == $past(code_val)
            && cif.out_code[0] == $past(code_val);
    endproperty
    a_bcast: assert property (p_bcast)
        else $error("Broadcast did not reach outputs");

    property p_pd_keep;
        @(posedge clk_sys) disable iff (rst)
        cif.frame_exec && command_nibble >= CMD_PD_HIZ
        |-> cif.hold_we == 8'h00 && cif.pd_we == flags;
    endproperty
    a_pd_keep: assert property (p_pd_keep)
        else $error("Power-down touched holding registers");

    property p_rd_zero;
        @(posedge clk_sys) disable iff (rst)
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("Read data outside the answer cycle");
endmodule
`default_nettype wire

/* dv/ocd_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ocd_host (
    // System clock paces the link
    input  wire logic clk_sys,
    // Link pins
    output logic      sclk,
    output logic      sync_n,
    output logic      din,
    input  wire logic dout
);
    logic [47:0] seen; // Chained output, newest in bit 0
    // Idle: sync high, data parked low
    initial begin
        sclk   = 1'b1;
        sync_n = 1'b1;
        din    = 1'b0;
        seen   = '0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Low n bits of w, msb first; sclk still outside frames
    task automatic frame(input logic [47:0] w, input int n);
        sync_n <= 1'b0;
        tick(4);
        for (int i = n - 1; i >= 0; i--) begin
            din <= w[i];
            tick(2);
            sclk <= 1'b0;
            tick(4);
            // Last fall: clock stays low until sync rises
            if (i > 0) begin
                sclk <= 1'b1;
            end
            tick(2);
            seen <= {seen[46:0], dout};
        end
        sync_n <= 1'b1;
        sclk   <= 1'b1;
        din    <= 1'b0;
        tick(8);
    endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ocd_pkg::*;
    logic        clk_sys   = 1'b0; // 250 MHz
    logic        rst       = 1'b1; // Async, high
    logic        sclk, sync_n, din, dout;
    logic [4:0]  reg_addr  = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [15:0] reg_rdata, dac_pd, pd_exp, rv;
    logic [79:0] dac_code;
    logic        write_through;
    logic [9:0]  hold [8]; // Expected holding codes
    logic [9:0]  outc [8]; // Expected output codes
    logic [31:0] cw;       // Chain stream
    int          mismatches  = 0;
    int          comparisons = 0;
    always #2 clk_sys = ~clk_sys;
    ocd_host u_host (.clk_sys(clk_sys), .sclk(sclk), .sync_n(sync_n),
        .din(din), .dout(dout));
    ocd_top u_ocd_top (.clk_sys(clk_sys), .rst(rst), .sclk(sclk),
        .sync_n(sync_n), .din(din), .dout(dout), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .dac_code(dac_code), .dac_pd(dac_pd),
        .write_through(write_through));
    task automatic chk(input string nm, input logic [79:0] e, g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Data taken at the edge closing its one-cycle slot
    task automatic rd(input logic [4:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        rv = reg_rdata;
    endtask
    task automatic check_all();
        logic [79:0] p;
        for (int i = 0; i < 8; i++) begin
            p[i*10 +: 10] = outc[i];
            rd(OFS_HOLD + 5'(i));
            chk("hold", 80'(hold[i]), 80'(rv));
            rd(OFS_OUT + 5'(i));
            chk("out_code", 80'(outc[i]), 80'(rv));
        end
        chk("dac_code", p, dac_code);
        chk("dac_pd", 80'(pd_exp), 80'(dac_pd));
    endtask
    task automatic send(input logic [15:0] w);
        u_host.frame(48'(w), 16);
        check_all();
    endtask
    task automatic wch(input logic [2:0] c, input logic [9:0] v, wt);
        hold[c] = v;
        if (wt) begin
            outc[c] = v;
        end
        send({1'b0, c, v, 2'b11});
    endtask
    task automatic t_reset();
        check_all();
        chk("mode", 80'(1'b0), 80'(write_through));
        rd(OFS_STATUS);
        chk("status", 80'h0, 80'(rv));
        rd(OFS_CTRL);
        chk("ctrl", 80'(CTRL_RESET), 80'(rv));
        wr(OFS_CTRL, 16'h0000);
        rd(OFS_CTRL);
        chk("ctrl", 80'h0, 80'(rv));
        wr(OFS_CTRL, 16'h0001);
        rd(5'h1F);
        chk("unmapped", 80'h0, 80'(rv));
        $display("test reset done");
    endtask
    task automatic t_frames();
        for (int i = 0; i < 8; i++) begin
            wch(3'(i), 10'(i * 113 + 7), 1'b0);
        end
        wch(3'h3, 10'h3FF, 1'b0);
        chk("dout", 80'h0002, 80'(u_host.seen[15:0]));
        u_host.frame(48'hC3FF, 14);
        u_host.frame(48'hC3FF, 15);
        check_all();
        send(16'h9000);
        chk("mode", 80'h1, 80'(write_through));
        wch(3'h7, 10'h3FF, 1'b1);
        wch(3'h1, 10'h001, 1'b1);
        send(16'h8000);
        chk("mode", 80'h0, 80'(write_through));
        wch(3'h2, 10'h155, 1'b0);
        $display("test frames done");
    endtask
    task automatic t_special();
        outc[0] = hold[0];
        outc[2] = hold[2];
        send(16'hA005);
        send(16'h9000);
        for (int i = 0; i < 8; i++) begin
            hold[i] = 10'h2AA;
            outc[i] = 10'h2AA;
        end
        send({4'hC, 10'h2AA, 2'b01});
        send(16'h8000);
        wch(3'h5, 10'h0F0, 1'b0);
        hold[0] = 10'h111;
        outc = hold;
        send({4'hB, 10'h111, 2'b10});
        for (int m = 1; m < 4; m++) begin
            for (int i = 0; i < 8; i++) begin
                if (i % 3 == m - 1) begin
                    pd_exp[2*i +: 2] = 2'(m);
                end
            end
            send({4'(m + 12), 12'(8'h49 << (m - 1))});
        end
        rd(OFS_STATUS);
        chk("status", 80'hFF00, 80'(rv));
        $display("test special done");
    endtask
    task automatic t_chain();
        cw = {16'hC000, 1'b0, 3'h6, 10'h2C4, 2'b00};
        hold[6] = 10'h2C4;
        u_host.frame(48'(cw), 32);
        check_all();
        chk("chain", 80'({15'h0001, cw[31:15]}),
            80'(u_host.seen[31:0]));
        $display("test chain done");
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 8; i++) begin
            hold[i] = 10'h000;
            outc[i] = 10'h000;
        end
        pd_exp = 16'h0000;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_frames();
        t_special();
        t_chain();
        end_of_test();
    end
endmodule
`default_nettype wire
